// File: verilog/ifd_instruction_field_decoder.sv
// Purpose: Splits fetched instruction words into designator fields.
// Assumes: Fetch logic and register operands share mclk; no synchronisers.
// Notes: All outputs except fetchReady are registered on the edge that accepts the word.
`timescale 1ns/1ps

module ifd_instruction_field_decoder (
  mclk,
  rst,
  fetchValid,
  fetchWord,
  opAValue,
  opXValue,
  opBValue,
  fetchReady,
  decValid,
  decIllegal,
  decFields,
  resultSelOdd,
  branchSum,
  branchBase
);

  input wire logic mclk;
  input wire logic rst;
  input wire logic fetchValid;
  input wire logic [63:0] fetchWord;
  input wire logic [63:0] opAValue;
  input wire logic [63:0] opXValue;
  input wire logic [63:0] opBValue;
  output logic fetchReady;
  output logic decValid;
  output logic decIllegal;
  output ifd_pkg::ifd_fields_t decFields;
  output logic resultSelOdd;
  output logic [63:0] branchSum;
  output logic [47:0] branchBase;

  // Handshake and output state
  logic readyReg;
  logic readyNext;
  logic validReg;
  logic validNext;
  logic illegalReg;
  logic illegalNext;
  logic oddReg;
  logic oddNext;
  ifd_pkg::ifd_fields_t fieldsReg;
  ifd_pkg::ifd_fields_t fieldsNext;
  logic [63:0] sumReg;
  logic [63:0] sumNext;
  logic [47:0] baseReg;
  logic [47:0] baseNext;

  // Combinational decode results
  logic accept;
  logic [7:0] code;
  logic [7:0] gField;
  logic [7:0] subBits;
  logic codeAssigned;
  logic codeLong;
  ifd_pkg::ifd_fmt_t codeFmt;
  logic [63:0] sumComb;
  logic [47:0] baseComb;
  logic [47:0] imm48;
  logic [15:0] imm16;
  logic [7:0] slotC;
  ifd_pkg::ifd_fields_t f;

  assign accept = fetchValid && readyReg;
  assign code = fetchWord[ifd_pkg::FUNC_MSB -: 8];
  assign gField = fetchWord[ifd_pkg::SUB_MSB -: 8];
  assign imm48 = fetchWord[ifd_pkg::IMM48_MSB -: ifd_pkg::IMM48_W];
  assign imm16 = fetchWord[ifd_pkg::IMM16_MSB -: ifd_pkg::IMM16_W];
  assign slotC = fetchWord[ifd_pkg::SLOT7_MSB -: 8];

  ifd_code_class u_class (
    .code(code),
    .assigned(codeAssigned),
    .isLong(codeLong),
    .fmt(codeFmt)
  );

  ifd_branch_sum u_sum (
    .opA(opAValue),
    .opX(opXValue),
    .opB(opBValue),
    .sum(sumComb),
    .base(baseComb)
  );

  // Subfunction bit i is the i-th bit from the left of the field
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sub
      assign subBits[gi] = gField[7 - gi];
    end
  endgenerate

  // Field extraction
  always_comb begin
    f = '0;
    f.funcCode = code;
    f.isLong = codeLong;
    f.fmt = codeFmt;
    f.subFunc = subBits;
    f.operandLong = subBits[ifd_pkg::G_LEN_BIT];
    f.broadcast = subBits[ifd_pkg::G_BCAST_BIT];
    f.selR = gField;
    f.selS = fetchWord[ifd_pkg::SLOT2_MSB -: 8];
    f.selT = fetchWord[ifd_pkg::SLOT3_MSB -: 8];
    if (codeLong) begin
      // Long vector, string and format C selector slots
      f.selX = fetchWord[ifd_pkg::SLOT2_MSB -: 8];
      f.selA = fetchWord[ifd_pkg::SLOT3_MSB -: 8];
      f.selY = fetchWord[ifd_pkg::SLOT4_MSB -: 8];
      f.selB = fetchWord[ifd_pkg::SLOT5_MSB -: 8];
      f.selZ = fetchWord[ifd_pkg::SLOT6_MSB -: 8];
      f.selC = slotC;
      f.selCNext = 8'(slotC + 8'h01);
    end
    case (codeFmt)
      ifd_pkg::FMT_IMM48: begin
        f.selR = gField;
        if (code == ifd_pkg::CODE_IX_CD || code == ifd_pkg::CODE_IX_CE) begin
          f.immOperand = {24'h0, imm48[ifd_pkg::IMM24_W-1:0]};
        end else begin
          f.immOperand = imm48;
        end
      end
      ifd_pkg::FMT_IMM16: begin
        f.selR = gField;
        f.immOperand = {32'h0, imm16};
      end
      ifd_pkg::FMT_BIT32: begin
        f.branchCond = {subBits[ifd_pkg::G_COND_BIT], subBits[ifd_pkg::G_COND_BIT+1]};
        f.bitAlter = {subBits[ifd_pkg::G_ALTER_BIT], subBits[ifd_pkg::G_ALTER_BIT+1]};
      end
      ifd_pkg::FMT_BIT33: begin
        f.branchCond = {subBits[ifd_pkg::G_COND_BIT], subBits[ifd_pkg::G_COND_BIT+1]};
        f.bitAlter = {subBits[ifd_pkg::G_ALTER_BIT], subBits[ifd_pkg::G_ALTER_BIT+1]};
        f.flagBitSel = fetchWord[ifd_pkg::BITSEL_MSB -: ifd_pkg::BITSEL_W];
      end
      ifd_pkg::FMT_BRC: begin
        f.selC = slotC;
      end
      default: begin
        // Short register style: R old state, T new state in format A
        f.selR = gField;
        f.selS = fetchWord[ifd_pkg::SLOT2_MSB -: 8];
        f.selT = fetchWord[ifd_pkg::SLOT3_MSB -: 8];
      end
    endcase
  end

  // Handshake group: ready from the first edge after reset
  always_comb begin
    readyNext = 1'b1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readyReg <= 1'b0;
    end else begin
      readyReg <= readyNext;
    end
  end

  // Answer group: one-cycle pulse per accepted word
  always_comb begin
    validNext = 1'b0;
    illegalNext = 1'b0;
    if (accept) begin
      validNext = codeAssigned;
      illegalNext = !codeAssigned;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      validReg <= 1'b0;
      illegalReg <= 1'b0;
    end else begin
      validReg <= validNext;
      illegalReg <= illegalNext;
    end
  end

  // Field group: held until the next accepted word
  always_comb begin
    fieldsNext = fieldsReg;
    oddNext = oddReg;
    if (accept) begin
      fieldsNext = f;
      oddNext = codeLong && slotC[0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fieldsReg <= '0;
      oddReg <= 1'b0;
    end else begin
      fieldsReg <= fieldsNext;
      oddReg <= oddNext;
    end
  end

  // Branch group: sum and base only for format C codes
  always_comb begin
    sumNext = sumReg;
    baseNext = baseReg;
    if (accept) begin
      if (codeFmt == ifd_pkg::FMT_BRC) begin
        sumNext = sumComb;
        baseNext = baseComb;
      end else begin
        sumNext = ifd_pkg::WORD_RST;
        baseNext = '0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sumReg <= ifd_pkg::WORD_RST;
      baseReg <= '0;
    end else begin
      sumReg <= sumNext;
      baseReg <= baseNext;
    end
  end

  assign fetchReady = readyReg;
  assign decValid = validReg;
  assign decIllegal = illegalReg;
  assign decFields = fieldsReg;
  assign resultSelOdd = oddReg;
  assign branchSum = sumReg;
  assign branchBase = baseReg;

endmodule

// File: verilog/ifd_pkg.sv
// Purpose: Shared constants and types for the instruction field decoder.
// Assumes: Instruction bit n, counted from the left, sits at word bit 63-n.
// Notes: 32-bit instructions occupy word bits 63:32, low half ignored.
//
// What this block does
// - Function code is the leftmost eight bits of every instruction, read as hex.
// - All 256 codes exist; unassigned codes are flagged and never marked valid.
// - Codes 00-7F are 32-bit words, codes 80-FF are 64-bit words.
// - Subfunction field comes from instruction bit positions 8 to 15.
// - Subfunction bit 0 is instruction bit 8, numbered left to right to 7.
// - Subfunction bits pick operand length and normal or broadcast sources.
// - Format 5 has destination in bits 8-15 and 48-bit immediate in 16-63.
// - CD and CE use low 24 immediate bits; BE and BF use all 48.
// - Format 6 has destination in bits 8-15 and 16-bit immediate in 16-31.
// - Format A takes old-state register from 8-15, new-state from 24-31.
// - Branch 33 carries a 6-bit immediate naming the tested flag bit.
// - Formats 9 and B hold a 2-bit branch condition inside subfunction.
// - Formats 9 and B hold a 2-bit object bit alter code in subfunction.
// - Format C result is 48-bit sum of A and X, top 16 bits zero.
// - Format C branch base is the low 48 bits of the B register.
// - Formats 1 and 3 source selectors name length and base registers.
// - Format 2 source selectors name base-address-only registers.
// - Formats 1 to 3 result selector names result length and base register.
// - Format 1 register after the result register supplies C and Z offset.

package ifd_pkg;

  localparam int WORD_W = 64;
  localparam int SEL_W = 8;
  // Most significant word bit of each byte slot, taken with -: 8
  localparam int FUNC_MSB = 63;
  localparam int SUB_MSB = 55;
  localparam int SLOT2_MSB = 47;
  localparam int SLOT3_MSB = 39;
  localparam int SLOT4_MSB = 31;
  localparam int SLOT5_MSB = 23;
  localparam int SLOT6_MSB = 15;
  localparam int SLOT7_MSB = 7;
  // Immediates
  localparam int IMM48_MSB = 47;
  localparam int IMM48_W = 48;
  localparam int IMM24_W = 24;
  localparam int IMM16_MSB = 47;
  localparam int IMM16_W = 16;
  localparam int BITSEL_MSB = 37;
  localparam int BITSEL_W = 6;
  // Code bit that picks a long word
  localparam int LONG_CODE_BIT = 7;
  // Subfunction bit numbers
  localparam int G_LEN_BIT = 0;
  localparam int G_BCAST_BIT = 1;
  localparam int G_COND_BIT = 0;
  localparam int G_ALTER_BIT = 2;
  localparam int ADDR_W = 48;
  localparam int CLR_W = 16;
  // Function codes
  localparam logic [7:0] CODE_REG2A = 8'h2a;
  localparam logic [7:0] CODE_BR32 = 8'h32;
  localparam logic [7:0] CODE_BR33 = 8'h33;
  localparam logic [7:0] CODE_IX3E = 8'h3e;
  localparam logic [7:0] CODE_IX3F = 8'h3f;
  localparam logic [7:0] CODE_IX4D = 8'h4d;
  localparam logic [7:0] CODE_IX4E = 8'h4e;
  localparam logic [7:0] CODE_BRC_LO = 8'hb0;
  localparam logic [7:0] CODE_BRC_HI = 8'hb5;
  localparam logic [7:0] CODE_BR_B6 = 8'hb6;
  localparam logic [7:0] CODE_IX_BE = 8'hbe;
  localparam logic [7:0] CODE_IX_BF = 8'hbf;
  localparam logic [7:0] CODE_IX_CD = 8'hcd;
  localparam logic [7:0] CODE_IX_CE = 8'hce;
  localparam logic [63:0] WORD_RST = 64'h0;

  typedef enum logic [2:0] {
    FMT_NONE,
    FMT_IMM48,
    FMT_IMM16,
    FMT_STATE,
    FMT_BIT32,
    FMT_BIT33,
    FMT_BRC
  } ifd_fmt_t;

  typedef struct packed {
    logic [7:0] funcCode;
    logic isLong;
    ifd_fmt_t fmt;
    logic [7:0] subFunc;
    logic operandLong;
    logic broadcast;
    logic [1:0] branchCond;
    logic [1:0] bitAlter;
    logic [7:0] selR;
    logic [7:0] selS;
    logic [7:0] selT;
    logic [7:0] selX;
    logic [7:0] selA;
    logic [7:0] selY;
    logic [7:0] selB;
    logic [7:0] selZ;
    logic [7:0] selC;
    logic [7:0] selCNext;
    logic [47:0] immOperand;
    logic [5:0] flagBitSel;
  } ifd_fields_t;

endpackage

// File: verilog/ifd_code_class.sv
// Purpose: Classifies a function code into format, length and assignment.
// Assumes: Pure combinational, same clock domain as the decoder.
// Notes: Only codes with a known field layout count as assigned.
`timescale 1ns/1ps

module ifd_code_class (
  input wire logic [7:0] code,
  output logic assigned,
  output logic isLong,
  output ifd_pkg::ifd_fmt_t fmt
);

  always_comb begin
    isLong = code[ifd_pkg::LONG_CODE_BIT];
    fmt = ifd_pkg::FMT_NONE;
    if (code >= ifd_pkg::CODE_BRC_LO && code <= ifd_pkg::CODE_BRC_HI) begin
      fmt = ifd_pkg::FMT_BRC;
    end
    case (code)
      ifd_pkg::CODE_IX_BE, ifd_pkg::CODE_IX_BF, ifd_pkg::CODE_IX_CD,
      ifd_pkg::CODE_IX_CE, ifd_pkg::CODE_BR_B6: fmt = ifd_pkg::FMT_IMM48;
      ifd_pkg::CODE_IX3E, ifd_pkg::CODE_IX3F, ifd_pkg::CODE_IX4D,
      ifd_pkg::CODE_IX4E, ifd_pkg::CODE_REG2A: fmt = ifd_pkg::FMT_IMM16;
      ifd_pkg::CODE_BR32: fmt = ifd_pkg::FMT_BIT32;
      ifd_pkg::CODE_BR33: fmt = ifd_pkg::FMT_BIT33;
      default: ;
    endcase
    assigned = (fmt != ifd_pkg::FMT_NONE);
  end

endmodule

// File: verilog/ifd_branch_sum.sv
// Purpose: Forms the format C index sum and branch base address.
// Assumes: Register operands arrive alongside the instruction word.
// Notes: Sum wraps modulo two to the 48th.
`timescale 1ns/1ps

module ifd_branch_sum (
  input wire logic [63:0] opA,
  input wire logic [63:0] opX,
  input wire logic [63:0] opB,
  output logic [63:0] sum,
  output logic [47:0] base
);

  logic [47:0] low;

  always_comb begin
    low = opA[ifd_pkg::ADDR_W-1:0] + opX[ifd_pkg::ADDR_W-1:0];
    sum = {{ifd_pkg::CLR_W{1'b0}}, low};
    base = opB[ifd_pkg::ADDR_W-1:0];
  end

endmodule

// File: verification/ifd_checker.sv
// Purpose: Port checks for the field decoder.
// Assumes: One mclk domain, rst asynchronous.
// Notes: Bound to the decoder top.
`timescale 1ns/1ps

module ifd_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fetchValid,
  input wire logic [63:0] fetchWord,
  input wire logic [63:0] opAValue,
  input wire logic [63:0] opXValue,
  input wire logic [63:0] opBValue,
  input wire logic fetchReady,
  input wire logic decValid,
  input wire logic decIllegal,
  input wire ifd_pkg::ifd_fields_t decFields,
  input wire logic [63:0] branchSum,
  input wire logic [47:0] branchBase
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic tk;
  logic [7:0] cd;
  logic [7:0] g;
  assign tk = fetchValid && fetchReady;
  assign cd = fetchWord[63:56];
  assign g = {<<{fetchWord[55:48]}};
  property p_answer; tk |=> decValid ^ decIllegal; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_quiet; !tk |=> !decValid && !decIllegal && $stable(decFields); endproperty
  a_quiet: assert property (p_quiet) else $error("output moved without take");
  property p_code; tk |=> decFields.funcCode == $past(cd); endproperty
  a_code: assert property (p_code) else $error("code wrong");
  property p_long; decValid |-> decFields.isLong == decFields.funcCode[7]; endproperty
  a_long: assert property (p_long) else $error("length wrong");
  property p_sub; tk |=> decFields.subFunc == $past(g); endproperty
  a_sub: assert property (p_sub) else $error("subfunction wrong");
  property p_cond;
    decValid && decFields.funcCode inside {8'h32, 8'h33} |->
      {decFields.branchCond, decFields.bitAlter} == {<<{decFields.subFunc[3:0]}};
  endproperty
  a_cond: assert property (p_cond) else $error("condition wrong");
  property p_sum;
    tk && cd inside {[8'hb0:8'hb5]} |=>
      branchSum == {16'h0, 48'($past(opAValue) + $past(opXValue))};
  endproperty
  a_sum: assert property (p_sum) else $error("sum wrong");
  property p_base;
    tk && cd inside {[8'hb0:8'hb5]} |=> branchBase == 48'($past(opBValue));
  endproperty
  a_base: assert property (p_base) else $error("base wrong");
  property p_imm; tk && cd == 8'hbe |=> decFields.immOperand == 48'($past(fetchWord)); endproperty
  a_imm: assert property (p_imm) else $error("immediate wrong");
  property p_flag;
    tk && cd == 8'h33 |=> decFields.flagBitSel == 6'($past(fetchWord) >> 32);
  endproperty
  a_flag: assert property (p_flag) else $error("flag bit wrong");
  property p_ready; fetchReady |=> fetchReady; endproperty
  a_ready: assert property (p_ready) else $error("ready dropped");
endmodule

bind ifd_instruction_field_decoder ifd_checker i_ifd_checker (.mclk, .rst, .fetchValid,
  .fetchWord, .opAValue, .opXValue, .opBValue, .fetchReady, .decValid, .decIllegal,
  .decFields, .branchSum, .branchBase);

// File: verification/ifd_fetch_model.sv
// Purpose: Fetch side model offering one word at a time.
// Assumes: Handshake on fetchValid and fetchReady.
// Notes: Released lines show the inverse of the last value.
`timescale 1ns/1ps

module ifd_fetch_model (
  input wire logic mclk,
  input wire logic fetchReady,
  output logic fetchValid,
  output logic [63:0] fetchWord,
  output logic [63:0] opAValue,
  output logic [63:0] opXValue,
  output logic [63:0] opBValue
);
  initial begin
    fetchValid = 1'b0;
    {fetchWord, opAValue, opXValue, opBValue} = '0;
  end
  task automatic send(input logic [63:0] w, a, x, b, output logic [63:0] v, output logic ok);
    int n;
    v = w;
    if (!w[63]) v[31:0] = 32'h0;
    else if (!(w[63:56] inside {[8'hb0:8'hb6], 8'hbe, 8'hbf, 8'hcd, 8'hce}))
      v[0] = 1'b0;
    @(posedge mclk);
    fetchValid <= 1'b1;
    fetchWord <= v;
    {opAValue, opXValue, opBValue} <= {a, x, b};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (fetchReady !== 1'b1 && n < 50);
    ok = fetchReady === 1'b1;
    fetchValid <= 1'b0;
    fetchWord <= ~v;
    {opAValue, opXValue, opBValue} <= ~{a, x, b};
  endtask
endmodule

// File: verification/test_instruction_field_decoder.sv
// Purpose: Self-checking bench for the field decoder.
// Assumes: Fetch model drives the word side.
// Notes: Every code in the table, then random codes.
`timescale 1ns/1ps

module test_instruction_field_decoder;
  logic mclk, rst, fetchValid, fetchReady, decValid, decIllegal, resultSelOdd;
  logic [63:0] fetchWord, opAValue, opXValue, opBValue, branchSum;
  logic [47:0] branchBase;
  ifd_pkg::ifd_fields_t decFields;
  int bad_count = 0;
  int checked = 0;
  logic [63:0] rs = 64'd45;
  logic [7:0] codes[$] = {8'h2a, 8'h32, 8'h33, 8'h3e, 8'h3f, 8'h4d, 8'h4e, 8'hb0, 8'hb1,
    8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hbe, 8'hbf, 8'hcd, 8'hce, 8'h00, 8'h7f, 8'hff};

  ifd_instruction_field_decoder i_ifd_instruction_field_decoder (.mclk, .rst, .fetchValid,
    .fetchWord, .opAValue, .opXValue, .opBValue, .fetchReady, .decValid, .decIllegal,
    .decFields, .resultSelOdd, .branchSum, .branchBase);
  ifd_fetch_model i_ifd_fetch_model (.mclk, .fetchReady, .fetchValid, .fetchWord,
    .opAValue, .opXValue, .opBValue);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [63:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 7;
    rs ^= rs << 17;
    return rs;
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic run(input logic [7:0] c);
    logic [63:0] w, a, x, b, v, ei;
    logic [7:0] g;
    logic [3:0] gc;
    logic ok, asg, brc;
    w = rnd();
    w[63:56] = c;
    a = rnd();
    x = rnd();
    b = rnd();
    i_ifd_fetch_model.send(w, a, x, b, v, ok);
    #1;
    if (!ok) begin
      chk("ready", 0, 1);
      final_report();
    end
    asg = 1'b0;
    foreach (codes[k]) if (k < 18 && codes[k] == c) asg = 1'b1;
    brc = c inside {[8'hb0:8'hb5]};
    for (int i = 0; i < 8; i++) g[i] = v[55-i];
    gc = {g[0], g[1], g[2], g[3]};
    chk("valid", decValid, asg);
    chk("illegal", decIllegal, !asg);
    if (asg) begin
      chk("code", decFields.funcCode, c);
      chk("long", decFields.isLong, c[7]);
      chk("sub", decFields.subFunc, g);
      chk("lenb", {decFields.broadcast, decFields.operandLong}, g[1:0]);
      chk("selR", decFields.selR, v[55:48]);
      if (!c[7]) chk("selT", decFields.selT, v[39:32]);
      else begin
        chk("sels", {decFields.selX, decFields.selA, decFields.selY, decFields.selB,
          decFields.selZ, decFields.selC}, v[47:0]);
        chk("next", decFields.selCNext, 8'(v[7:0] + 8'h1));
      end
      chk("odd", resultSelOdd, c[7] & v[0]);
      ei = '1;
      if (c inside {8'hbe, 8'hbf, 8'hb6}) ei = {16'h0, v[47:0]};
      if (c inside {8'hcd, 8'hce}) ei = {40'h0, v[23:0]};
      if (c inside {8'h2a, 8'h3e, 8'h3f, 8'h4d, 8'h4e}) ei = {48'h0, v[47:32]};
      if (ei !== '1) chk("imm", decFields.immOperand, ei);
      if (c == 8'h33) chk("flag", decFields.flagBitSel, v[37:32]);
      if (c inside {8'h32, 8'h33})
        chk("cond", {decFields.branchCond, decFields.bitAlter}, gc);
      chk("sum", branchSum, brc ? {16'h0, 48'(a + x)} : 64'h0);
      chk("base", branchBase, brc ? b[47:0] : 48'h0);
    end
    @(posedge mclk);
    #1;
    chk("pulse", {decValid, decIllegal}, 0);
  endtask

  initial begin
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("ready", fetchReady, 1);
    foreach (codes[k]) run(codes[k]);
    repeat (60) run(8'(rnd()));
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    #1;
    chk("rst", {fetchReady, decValid, decIllegal, resultSelOdd}, 0);
    chk("rstsum", branchSum, 0);
    chk("rstbase", branchBase, 0);
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    run(8'hb2);
    final_report();
  end
endmodule
